// *** hw/ccsr_params.svh ***
// Offsets, field positions, reset values and masks of the core state block.
// Assumes a data space with the register file at 0x00 and I/O above it.
`ifndef CCSR_PARAMS_SVH
`define CCSR_PARAMS_SVH

// Status flag positions
`define CCSR_BIT_GIE        3'd7
`define CCSR_BIT_COPY       3'd6
`define CCSR_BIT_HALF       3'd5
`define CCSR_BIT_SIGN       3'd4
`define CCSR_BIT_OVF        3'd3
`define CCSR_BIT_NEG        3'd2
`define CCSR_BIT_ZERO       3'd1
`define CCSR_BIT_CARRY      3'd0

// I/O offsets and the data-space base of the I/O window
`define CCSR_IO_BASE        16'h0020
`define CCSR_IO_PTR_EXT     16'h003b
`define CCSR_IO_SP_LOW      16'h003d
`define CCSR_IO_SP_HIGH     16'h003e
`define CCSR_IO_STATUS      16'h003f
`define CCSR_REGFILE_TOP    16'h0020

// Pointer pair base indices
`define CCSR_PTR_X_IDX      5'd26
`define CCSR_PTR_Y_IDX      5'd28
`define CCSR_PTR_Z_IDX      5'd30

// Reset values and implemented-bit masks
`define CCSR_SP_RESET       16'h10ff
`define CCSR_SP_MASK        16'h1fff
`define CCSR_PTR_EXT_RESET  8'h00
`define CCSR_PTR_EXT_MASK   8'h01
`define CCSR_STATUS_RESET   8'h00
`define CCSR_REG_RESET      8'h00

`endif

// *** hw/ccsr_pkg.sv ***
// Types shared by the core state block and its neighbours.
// Assumes nothing beyond the constants header.
package ccsr_pkg;

  typedef enum logic [1:0] {
    CCSR_ALU_NONE  = 2'h0,
    CCSR_ALU_ADD   = 2'h1,
    CCSR_ALU_SUB   = 2'h2,
    CCSR_ALU_LOGIC = 2'h3
  } ccsr_alu_op_type;

  typedef enum logic [2:0] {
    CCSR_SP_NONE  = 3'h0,
    CCSR_SP_PUSH1 = 3'h1,
    CCSR_SP_POP1  = 3'h2,
    CCSR_SP_PUSH3 = 3'h3,
    CCSR_SP_POP3  = 3'h4
  } ccsr_sp_op_type;

  typedef enum logic [1:0] {
    CCSR_PTR_NONE    = 2'h0,
    CCSR_PTR_DISP    = 2'h1,
    CCSR_PTR_POSTINC = 2'h2,
    CCSR_PTR_PREDEC  = 2'h3
  } ccsr_ptr_op_type;

  typedef struct packed {
    logic        en;
    logic        wide;
    logic [4:0]  idx;
    logic [15:0] data;
  } ccsr_wr_type;

  typedef struct packed {
    ccsr_alu_op_type op;
    logic [7:0]      a;
    logic [7:0]      b;
    logic [7:0]      r;
  } ccsr_alu_type;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ccsr_ds_type;

endpackage

// *** hw/ccsr_core.sv ***
// Architectural state of the 8-bit core: status flags, 32-entry register
// file with three pointer pairs, stack pointer and pointer extension byte.
// Assumes the execution logic and ALU drive all request inputs on sys_clk_i;
// results are computed outside, flags are derived here.
`timescale 1ns/1ns
`include "ccsr_params.svh"

module ccsr_core (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [4:0]               rd_a_idx_i,
  input  wire logic [4:0]               rd_b_idx_i,
  input  wire ccsr_pkg::ccsr_wr_type    wr_i,
  input  wire ccsr_pkg::ccsr_alu_type   alu_i,
  input  wire logic                     bit_store_op_i,
  input  wire logic                     bit_load_op_i,
  input  wire logic [2:0]               bit_sel_i,
  input  wire logic                     flag_clear_op_i,
  input  wire logic                     flag_set_op_i,
  input  wire logic                     irq_take_i,
  input  wire logic                     interrupt_exit_op_i,
  input  wire logic [7:0]               src_enable_i,
  input  wire ccsr_pkg::ccsr_sp_op_type sp_op_i,
  input  wire logic [1:0]               ptr_sel_i,
  input  wire ccsr_pkg::ccsr_ptr_op_type ptr_op_i,
  input  wire logic [5:0]               ptr_disp_i,
  input  wire logic                     extended_table_read_i,
  input  wire ccsr_pkg::ccsr_ds_type    ds_i,
  output logic [7:0]                    rd_a_o,
  output logic [7:0]                    rd_b_o,
  output logic [15:0]                   rd_wide_o,
  output logic [7:0]                    ds_rdata_o,
  output logic [15:0]                   ptr_addr_o,
  output logic [23:0]                   prog_addr_o,
  output logic [15:0]                   stack_ptr_o,
  output logic [7:0]                    status_flags_o,
  output logic [7:0]                    irq_enabled_o
);

  logic        rst_meta;
  logic        rst_sync_n;
  logic [7:0]  regs      [32];
  logic [7:0]  next_regs [32];
  logic [7:0]  status_flags_reg;
  logic [7:0]  next_status;
  logic [15:0] stack_ptr;
  logic [15:0] next_sp;
  logic [7:0]  pointer_extension_byte;
  logic [4:0]  ptr_base;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [15:0] ptr_eff;
  logic        ptr_upd;
  logic        ds_reg_hit;
  logic [15:0] io_off;
  logic        h_flag;
  logic        v_flag;
  logic        c_flag;
  logic        n_flag;
  logic        z_flag;
  logic [4:0]  wr_hi_idx;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Decode of data-space accesses
  assign ds_reg_hit = ds_i.addr < `CCSR_REGFILE_TOP;
  assign io_off     = ds_i.addr - `CCSR_IO_BASE;
  assign wr_hi_idx  = {wr_i.idx[4:1], 1'b1};

  // Pointer pair select and effective address
  always_comb begin
    unique case (ptr_sel_i)
      2'h0:    ptr_base = `CCSR_PTR_X_IDX;
      2'h1:    ptr_base = `CCSR_PTR_Y_IDX;
      default: ptr_base = `CCSR_PTR_Z_IDX;
    endcase
  end

  assign ptr_cur = {regs[ptr_base + 5'd1], regs[ptr_base]};

  // Displacement leaves the pointer; inc and dec write it back
  always_comb begin
    ptr_new = ptr_cur;
    ptr_eff = ptr_cur;
    ptr_upd = 1'b0;
    unique case (ptr_op_i)
      ccsr_pkg::CCSR_PTR_NONE: begin
        ptr_eff = ptr_cur;
      end
      ccsr_pkg::CCSR_PTR_DISP: begin
        ptr_eff = ptr_cur + {10'h000, ptr_disp_i};
      end
      ccsr_pkg::CCSR_PTR_POSTINC: begin
        ptr_new = ptr_cur + 16'h0001;
        ptr_upd = 1'b1;
      end
      ccsr_pkg::CCSR_PTR_PREDEC: begin
        ptr_new = ptr_cur - 16'h0001;
        ptr_eff = ptr_new;
        ptr_upd = 1'b1;
      end
    endcase
  end

  // Per-entry next value; later sources win, the result port last
  for (genvar g = 0; g < 32; g++) begin : g_entry
    always_comb begin
      next_regs[g] = regs[g];
      if (ds_i.we && ds_reg_hit && ds_i.addr[4:0] == 5'(g)) begin
        next_regs[g] = ds_i.wdata;
      end
      if (ptr_upd && ptr_base == 5'(g)) begin
        next_regs[g] = ptr_new[7:0];
      end
      if (ptr_upd && ptr_base + 5'd1 == 5'(g)) begin
        next_regs[g] = ptr_new[15:8];
      end
      if (bit_load_op_i && rd_a_idx_i == 5'(g)) begin
        next_regs[g][bit_sel_i] = status_flags_reg[`CCSR_BIT_COPY];
      end
      if (wr_i.en && !wr_i.wide && wr_i.idx == 5'(g)) begin
        next_regs[g] = wr_i.data[7:0];
      end
      if (wr_i.en && wr_i.wide && {wr_i.idx[4:1], 1'b0} == 5'(g)) begin
        next_regs[g] = wr_i.data[7:0];
      end
      if (wr_i.en && wr_i.wide && wr_hi_idx == 5'(g)) begin
        next_regs[g] = wr_i.data[15:8];
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        regs[g] <= `CCSR_REG_RESET;
      end else begin
        regs[g] <= next_regs[g];
      end
    end
  end

  // Read ports sample post-write state, so a write is seen at once
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_a_o    <= 8'h00;
      rd_b_o    <= 8'h00;
      rd_wide_o <= 16'h0000;
    end else begin
      rd_a_o    <= next_regs[rd_a_idx_i];
      rd_b_o    <= next_regs[rd_b_idx_i];
      rd_wide_o <= {next_regs[{rd_a_idx_i[4:1], 1'b1}],
                    next_regs[{rd_a_idx_i[4:1], 1'b0}]};
    end
  end

  // Flag derivation from operands and result
  always_comb begin
    n_flag = alu_i.r[7];
    z_flag = alu_i.r == 8'h00;
    h_flag = status_flags_reg[`CCSR_BIT_HALF];
    c_flag = status_flags_reg[`CCSR_BIT_CARRY];
    v_flag = 1'b0;
    unique case (alu_i.op)
      ccsr_pkg::CCSR_ALU_ADD: begin
        h_flag = (alu_i.a[3] & alu_i.b[3]) | (alu_i.b[3] & ~alu_i.r[3])
               | (~alu_i.r[3] & alu_i.a[3]);
        c_flag = (alu_i.a[7] & alu_i.b[7]) | (alu_i.b[7] & ~alu_i.r[7])
               | (~alu_i.r[7] & alu_i.a[7]);
        v_flag = (alu_i.a[7] & alu_i.b[7] & ~alu_i.r[7])
               | (~alu_i.a[7] & ~alu_i.b[7] & alu_i.r[7]);
      end
      ccsr_pkg::CCSR_ALU_SUB: begin
        h_flag = (~alu_i.a[3] & alu_i.b[3]) | (alu_i.b[3] & alu_i.r[3])
               | (alu_i.r[3] & ~alu_i.a[3]);
        c_flag = (~alu_i.a[7] & alu_i.b[7]) | (alu_i.b[7] & alu_i.r[7])
               | (alu_i.r[7] & ~alu_i.a[7]);
        v_flag = (alu_i.a[7] & ~alu_i.b[7] & ~alu_i.r[7])
               | (~alu_i.a[7] & alu_i.b[7] & alu_i.r[7]);
      end
      ccsr_pkg::CCSR_ALU_LOGIC: begin
        v_flag = 1'b0;
      end
      ccsr_pkg::CCSR_ALU_NONE: begin
        v_flag = status_flags_reg[`CCSR_BIT_OVF];
      end
    endcase
  end

  // Status next value; hardware set of the enable beats every clear
  always_comb begin
    next_status = status_flags_reg;
    if (ds_i.we && ds_i.addr == `CCSR_IO_BASE + `CCSR_IO_STATUS) begin
      next_status = ds_i.wdata;
    end
    if (flag_set_op_i) begin
      next_status[`CCSR_BIT_GIE] = 1'b1;
    end
    if (flag_clear_op_i) begin
      next_status[`CCSR_BIT_GIE] = 1'b0;
    end
    if (irq_take_i) begin
      next_status[`CCSR_BIT_GIE] = 1'b0;
    end
    if (interrupt_exit_op_i) begin
      next_status[`CCSR_BIT_GIE] = 1'b1;
    end
    if (bit_store_op_i) begin
      next_status[`CCSR_BIT_COPY] = regs[rd_a_idx_i][bit_sel_i];
    end
    if (alu_i.op != ccsr_pkg::CCSR_ALU_NONE) begin
      next_status[`CCSR_BIT_HALF]  = h_flag;
      next_status[`CCSR_BIT_OVF]   = v_flag;
      next_status[`CCSR_BIT_NEG]   = n_flag;
      next_status[`CCSR_BIT_ZERO]  = z_flag;
      next_status[`CCSR_BIT_CARRY] = c_flag;
    end
    // Sign is derived, so even a software write cannot break it
    next_status[`CCSR_BIT_SIGN] = next_status[`CCSR_BIT_NEG]
                                ^ next_status[`CCSR_BIT_OVF];
  end

  // Nothing is pushed or popped here on entry or exit
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_flags_reg <= `CCSR_STATUS_RESET;
    end else begin
      status_flags_reg <= next_status;
    end
  end

  // Stack pointer: byte writes, replaced by any stack operation on the old value
  always_comb begin
    next_sp = stack_ptr;
    if (ds_i.we && ds_i.addr == `CCSR_IO_BASE + `CCSR_IO_SP_LOW) begin
      next_sp[7:0] = ds_i.wdata;
    end
    if (ds_i.we && ds_i.addr == `CCSR_IO_BASE + `CCSR_IO_SP_HIGH) begin
      next_sp[15:8] = ds_i.wdata;
    end
    unique case (sp_op_i)
      ccsr_pkg::CCSR_SP_NONE:  next_sp = next_sp;
      ccsr_pkg::CCSR_SP_PUSH1: next_sp = stack_ptr - 16'h0001;
      ccsr_pkg::CCSR_SP_POP1:  next_sp = stack_ptr + 16'h0001;
      ccsr_pkg::CCSR_SP_PUSH3: next_sp = stack_ptr - 16'h0003;
      ccsr_pkg::CCSR_SP_POP3:  next_sp = stack_ptr + 16'h0003;
      default:                 next_sp = next_sp;
    endcase
    // Upper bits are not built; they read as zero
    next_sp = next_sp & `CCSR_SP_MASK;
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stack_ptr <= `CCSR_SP_RESET;
    end else begin
      stack_ptr <= next_sp;
    end
  end

  // Extension byte keeps only its implemented bits
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pointer_extension_byte <= `CCSR_PTR_EXT_RESET;
    end else if (ds_i.we && ds_i.addr == `CCSR_IO_BASE + `CCSR_IO_PTR_EXT) begin
      pointer_extension_byte <= ds_i.wdata & `CCSR_PTR_EXT_MASK;
    end
  end

  // Data-space read: registers below the I/O window, then owned I/O bytes
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ds_rdata_o <= 8'h00;
    end else if (!ds_i.re) begin
      ds_rdata_o <= 8'h00;
    end else if (ds_reg_hit) begin
      ds_rdata_o <= regs[ds_i.addr[4:0]];
    end else begin
      unique case (io_off)
        `CCSR_IO_PTR_EXT: ds_rdata_o <= pointer_extension_byte;
        `CCSR_IO_SP_LOW:  ds_rdata_o <= stack_ptr[7:0];
        `CCSR_IO_SP_HIGH: ds_rdata_o <= stack_ptr[15:8];
        `CCSR_IO_STATUS:  ds_rdata_o <= status_flags_reg;
        default:          ds_rdata_o <= 8'h00;
      endcase
    end
  end

  // Pointer address outputs; plain table reads see only the low word
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_addr_o  <= 16'h0000;
      prog_addr_o <= 24'h000000;
    end else begin
      ptr_addr_o <= ptr_eff;
      if (extended_table_read_i) begin
        prog_addr_o <= {pointer_extension_byte,
                        regs[`CCSR_PTR_Z_IDX + 5'd1], regs[`CCSR_PTR_Z_IDX]};
      end else begin
        prog_addr_o <= {8'h00,
                        regs[`CCSR_PTR_Z_IDX + 5'd1], regs[`CCSR_PTR_Z_IDX]};
      end
    end
  end

  // Registered state mirrors; the gate uses the enable after this cycle
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stack_ptr_o    <= `CCSR_SP_RESET;
      status_flags_o <= `CCSR_STATUS_RESET;
      irq_enabled_o  <= 8'h00;
    end else begin
      stack_ptr_o    <= next_sp;
      status_flags_o <= next_status;
      irq_enabled_o  <= src_enable_i & {8{next_status[`CCSR_BIT_GIE]}};
    end
  end

endmodule // ccsr_core

// *** verification/ccsr_core_sva.sv ***
// Port-level checks on the core state block.
// Assumes one clock and a reset pin that the block syncs through two flops.
`timescale 1ns/1ns
`include "ccsr_params.svh"
module ccsr_core_sva (
  input wire logic                     sys_clk_i,
  input wire logic                     rst_n_i,
  input wire logic [4:0]               rd_a_idx_i,
  input wire ccsr_pkg::ccsr_wr_type    wr_i,
  input wire ccsr_pkg::ccsr_alu_type   alu_i,
  input wire logic                     irq_take_i,
  input wire logic                     interrupt_exit_op_i,
  input wire logic [7:0]               src_enable_i,
  input wire ccsr_pkg::ccsr_sp_op_type sp_op_i,
  input wire ccsr_pkg::ccsr_ds_type    ds_i,
  input wire logic [7:0]               rd_a_o,
  input wire logic [7:0]               ds_rdata_o,
  input wire logic [15:0]              stack_ptr_o,
  input wire logic [7:0]               status_flags_o,
  input wire logic [7:0]               irq_enabled_o
);
  logic [2:0]  live_age;
  logic [15:0] sp_step;
  wire         live  = live_age[2];
  wire         add_c = alu_i.a[7] & alu_i.b[7] | alu_i.b[7] & ~alu_i.r[7]
                     | ~alu_i.r[7] & alu_i.a[7];
  wire         add_h = alu_i.a[3] & alu_i.b[3] | alu_i.b[3] & ~alu_i.r[3]
                     | ~alu_i.r[3] & alu_i.a[3];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Inner reset lags the pin, so checks wait a third edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) live_age <= 3'h0;
    else live_age <= {live_age[1:0], 1'b1};
  end

  // Signed step of each stack operation
  always_comb begin
    case (sp_op_i)
      ccsr_pkg::CCSR_SP_PUSH1: sp_step = 16'hffff;
      ccsr_pkg::CCSR_SP_POP1:  sp_step = 16'h0001;
      ccsr_pkg::CCSR_SP_PUSH3: sp_step = 16'hfffd;
      ccsr_pkg::CCSR_SP_POP3:  sp_step = 16'h0003;
      default:                 sp_step = 16'h0000;
    endcase
  end

  sequence s_alu_on;
    live && alu_i.op != ccsr_pkg::CCSR_ALU_NONE;
  endsequence
  sequence s_add_on;
    live && alu_i.op == ccsr_pkg::CCSR_ALU_ADD;
  endsequence

  a_sign_is_xor:
    assert property (status_flags_o[4] == (status_flags_o[2] ^ status_flags_o[3]))
    else $error("sign flag differs from negative xor overflow");
  a_gate_by_global:
    assert property (live |=> irq_enabled_o == ($past(src_enable_i) & {8{status_flags_o[7]}}))
    else $error("source enable passed without global enable");
  a_entry_clears_gie:
    assert property (live && irq_take_i && !interrupt_exit_op_i |=> !status_flags_o[7])
    else $error("global enable kept after interrupt entry");
  a_exit_sets_gie:
    assert property (live && interrupt_exit_op_i |=> status_flags_o[7])
    else $error("global enable not set by interrupt exit");
  a_sp_byte_step:
    assert property (live && sp_op_i inside {ccsr_pkg::CCSR_SP_PUSH1, ccsr_pkg::CCSR_SP_POP1}
      |=> stack_ptr_o == (($past(stack_ptr_o) + $past(sp_step)) & `CCSR_SP_MASK))
    else $error("stack pointer byte step wrong");
  a_sp_call_step:
    assert property (live && sp_op_i inside {ccsr_pkg::CCSR_SP_PUSH3, ccsr_pkg::CCSR_SP_POP3}
      |=> stack_ptr_o == (($past(stack_ptr_o) + $past(sp_step)) & `CCSR_SP_MASK))
    else $error("stack pointer call step wrong");
  a_zero_flag:
    assert property (s_alu_on |=> status_flags_o[1] == ($past(alu_i.r) == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag:
    assert property (s_alu_on |=> status_flags_o[2] == $past(alu_i.r[7]))
    else $error("negative flag wrong");
  a_add_carry:
    assert property (s_add_on |=> status_flags_o[0] == $past(add_c))
    else $error("carry flag wrong after add");
  a_add_half:
    assert property (s_add_on |=> status_flags_o[5] == $past(add_h))
    else $error("half carry wrong after add");
  a_ext_reads_zero:
    assert property (live && ds_i.re && ds_i.addr == 16'h005b |=> ds_rdata_o[7:1] == 7'h00)
    else $error("unused extension bits read as one");
  a_write_forward:
    assert property (live && wr_i.en && !wr_i.wide && wr_i.idx == rd_a_idx_i
      |=> rd_a_o == $past(wr_i.data[7:0]))
    else $error("operand read misses same cycle write");
endmodule // ccsr_core_sva

bind ccsr_core ccsr_core_sva u_sva (.*);

// *** verification/ccsr_exec_model.sv ***
// Behavioural execution unit: forms ALU results that the core flags follow.
// Assumes the bench drives opcode and operands just after the clock edge.
`timescale 1ns/1ns
module ccsr_exec_model (
  input  wire ccsr_pkg::ccsr_alu_op_type op_i,
  input  wire logic [7:0]                a_i,
  input  wire logic [7:0]                b_i,
  output ccsr_pkg::ccsr_alu_type         alu_o
);
  // Status is never stacked here; software keeps it if needed
  always_comb begin
    alu_o.op = op_i;
    alu_o.a  = a_i;
    alu_o.b  = b_i;
    case (op_i)
      ccsr_pkg::CCSR_ALU_ADD: alu_o.r = a_i + b_i;
      ccsr_pkg::CCSR_ALU_SUB: alu_o.r = a_i - b_i;
      default:                alu_o.r = a_i & b_i;
    endcase
  end
endmodule // ccsr_exec_model

// *** verification/testbench.sv ***
// Self-checking bench for the core state block and its executor model.
// Assumes design, checker and model files are compiled before it.
`timescale 1ns/1ns
`include "ccsr_params.svh"
module testbench;
  logic                      sys_clk_i, rst_n_i, bstore, bload, fclr, fset, itake, iexit, ext;
  logic [4:0]                ia, ib;
  logic [2:0]                bsel;
  logic [5:0]                disp;
  logic [1:0]                psel;
  logic [7:0]                src, ra, rb, dsr, st, ien, a, b, t;
  logic [7:0]                rf [32];
  logic [7:0]                ca [3] = '{8'h08, 8'h80, 8'h00};
  logic [7:0]                cb [3] = '{8'h08, 8'h80, 8'h01};
  logic [15:0]               rw, pa, sp, e;
  logic [23:0]               pga;
  ccsr_pkg::ccsr_wr_type     wr;
  ccsr_pkg::ccsr_alu_type    alu;
  ccsr_pkg::ccsr_alu_op_type op;
  ccsr_pkg::ccsr_sp_op_type  spop;
  ccsr_pkg::ccsr_ptr_op_type pop;
  ccsr_pkg::ccsr_ds_type     ds;
  int                        failures, tests_run;

  ccsr_exec_model exe (.op_i(op), .a_i(a), .b_i(b), .alu_o(alu));
  ccsr_core dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rd_a_idx_i(ia), .rd_b_idx_i(ib),
    .wr_i(wr), .alu_i(alu), .bit_store_op_i(bstore), .bit_load_op_i(bload), .bit_sel_i(bsel),
    .flag_clear_op_i(fclr), .flag_set_op_i(fset), .irq_take_i(itake),
    .interrupt_exit_op_i(iexit), .src_enable_i(src), .sp_op_i(spop), .ptr_sel_i(psel),
    .ptr_op_i(pop), .ptr_disp_i(disp), .extended_table_read_i(ext), .ds_i(ds),
    .rd_a_o(ra), .rd_b_o(rb), .rd_wide_o(rw), .ds_rdata_o(dsr), .ptr_addr_o(pa),
    .prog_addr_o(pga), .stack_ptr_o(sp), .status_flags_o(st), .irq_enabled_o(ien));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task tick;
    @(posedge sys_clk_i);
    #1;
  endtask

  task chk(input logic [23:0] g, input logic [23:0] x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected status after one ALU step; logic ops keep half and carry
  function automatic logic [7:0] fl(input ccsr_pkg::ccsr_alu_op_type o,
                                    input logic [7:0] x, input logic [7:0] y,
                                    input logic [7:0] f);
    logic [7:0] r;
    logic       h, v, c;
    r = (o == ccsr_pkg::CCSR_ALU_ADD) ? x + y : (o == ccsr_pkg::CCSR_ALU_SUB) ? x - y : x & y;
    {h, v, c} = {f[5], 1'b0, f[0]};
    if (o == ccsr_pkg::CCSR_ALU_NONE) return f;
    if (o == ccsr_pkg::CCSR_ALU_ADD) begin
      h = x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3];
      c = x[7] & y[7] | y[7] & ~r[7] | ~r[7] & x[7];
      v = x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7];
    end else if (o == ccsr_pkg::CCSR_ALU_SUB) begin
      h = ~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3];
      c = ~x[7] & y[7] | y[7] & r[7] | r[7] & ~x[7];
      v = x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7];
    end
    return {f[7:6], h, r[7] ^ v, v, r[7], r == 8'h00, c};
  endfunction

  function automatic logic [15:0] spd(input ccsr_pkg::ccsr_sp_op_type o);
    case (o)
      ccsr_pkg::CCSR_SP_PUSH1: return 16'hffff;
      ccsr_pkg::CCSR_SP_POP1:  return 16'h0001;
      ccsr_pkg::CCSR_SP_PUSH3: return 16'hfffd;
      ccsr_pkg::CCSR_SP_POP3:  return 16'h0003;
      default:                 return 16'h0000;
    endcase
  endfunction

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #20000;
    failures++;
    end_sim;
  end

  initial begin
    {rst_n_i, bstore, bload, fclr, fset, itake, iexit, ext, ia, ib, bsel, disp, psel, src} = '0;
    {a, b, wr, ds} = '0;
    op = ccsr_pkg::CCSR_ALU_NONE;
    spop = ccsr_pkg::CCSR_SP_NONE;
    pop = ccsr_pkg::CCSR_PTR_NONE;
    void'($urandom(32'hefad7cb1));
    repeat (20) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) tick;
    chk(sp, 16'h10ff);
    chk(st, 8'h00);
    for (int i = 0; i < 32; i++) begin
      rf[i] = 8'($urandom);
      wr = '{1'b1, 1'b0, 5'(i), {8'h00, rf[i]}};
      ia = 5'(i);
      tick;
      chk(ra, rf[i]);
    end
    wr.en = 1'b0;
    for (int i = 0; i < 32; i++) begin
      ds = '{1'b0, 1'b1, 16'(i), 8'h00};
      ib = 5'(31 - i);
      tick;
      chk(dsr, rf[i]);
      chk(rb, rf[31 - i]);
    end
    rf[7] = 8'($urandom);
    ds = '{1'b1, 1'b0, 16'h0007, rf[7]};
    ia = 5'd7;
    tick;
    chk(ra, rf[7]);
    ds = '0;
    $display("test register file done");
    for (int p = 0; p < 3; p++) begin
      e = 16'($urandom);
      disp = 6'($urandom);
      wr = '{1'b1, 1'b1, 5'(26 + 2 * p), e};
      ia = 5'(26 + 2 * p);
      psel = 2'(p);
      pop = ccsr_pkg::CCSR_PTR_NONE;
      tick;
      chk(rw, e);
      wr.en = 1'b0;
      pop = ccsr_pkg::CCSR_PTR_DISP;
      tick;
      chk(pa, e + 16'(disp));
      pop = ccsr_pkg::CCSR_PTR_POSTINC;
      tick;
      chk(pa, e);
      pop = ccsr_pkg::CCSR_PTR_PREDEC;
      tick;
      chk(pa, e);
      chk(rw, e);
    end
    pop = ccsr_pkg::CCSR_PTR_NONE;
    ds = '{1'b0, 1'b1, 16'h005b, 8'h00};
    tick;
    chk(dsr, 8'h00);
    ds = '{1'b1, 1'b0, 16'h005b, 8'hff};
    tick;
    ds = '{1'b0, 1'b1, 16'h005b, 8'h00};
    ext = 1'b1;
    tick;
    chk(dsr, 8'h01);
    chk(pga, {8'h01, e});
    ds = '{1'b0, 1'b1, 16'h0060, 8'h00};
    ext = 1'b0;
    tick;
    chk(dsr, 8'h00);
    chk(pga, {8'h00, e});
    $display("test pointers done");
    e = {4'h0, 4'h2 + 4'($urandom % 13), 8'($urandom)};
    ds = '{1'b1, 1'b0, 16'h005d, e[7:0]};
    tick;
    ds = '{1'b1, 1'b0, 16'h005e, e[15:8]};
    tick;
    chk(sp, e);
    ds = '0;
    for (int i = 0; i < 40; i++) begin
      spop = ccsr_pkg::ccsr_sp_op_type'($urandom % 5);
      e = (e + spd(spop)) & `CCSR_SP_MASK;
      tick;
      chk(sp, e);
    end
    spop = ccsr_pkg::CCSR_SP_NONE;
    ds = '{1'b0, 1'b1, 16'h005d, 8'h00};
    tick;
    chk(dsr, e[7:0]);
    ds = '{1'b0, 1'b1, 16'h005e, 8'h00};
    tick;
    chk(dsr, e[15:8]);
    $display("test stack done");
    // Software write to status; sign must still follow negative and overflow
    t = 8'($urandom);
    ds = '{1'b1, 1'b0, 16'h005f, t};
    tick;
    t[4] = t[2] ^ t[3];
    chk(st, t);
    ds = '{1'b0, 1'b1, 16'h005f, 8'h00};
    tick;
    chk(dsr, t);
    ds = '0;
    for (int i = 0; i < 60; i++) begin
      op = (i < 2) ? ccsr_pkg::CCSR_ALU_ADD : (i == 2) ? ccsr_pkg::CCSR_ALU_SUB
         : ccsr_pkg::ccsr_alu_op_type'($urandom % 4);
      a = (i < 3) ? ca[i] : 8'($urandom);
      b = (i < 3) ? cb[i] : 8'($urandom);
      tick;
      t = fl(op, a, b, t);
      chk(st, t);
    end
    op = ccsr_pkg::CCSR_ALU_NONE;
    $display("test flags done");
    // Same-cycle pairs last: exit beats entry, clear and entry beat set
    for (int i = 0; i < 8; i++) begin
      {fset, fclr, itake, iexit} = (i < 5) ? 4'h1 << (i % 4)
                                 : (i == 5) ? 4'h3 : (i == 6) ? 4'hc : 4'ha;
      src = 8'($urandom);
      tick;
      t[7] = iexit | (~itake & ~fclr & (fset | t[7]));
      chk(st, t);
      chk(ien, src & {8{t[7]}});
    end
    {fset, fclr, itake, iexit, bstore, ia} = {4'h0, 1'b1, 5'd3};
    bsel = 3'($urandom);
    tick;
    t[6] = rf[3][bsel];
    chk(st, t);
    {bstore, bload, ia} = {1'b0, 1'b1, 5'd4};
    bsel = 3'($urandom);
    tick;
    rf[4][bsel] = t[6];
    chk(ra, rf[4]);
    bload = 1'b0;
    $display("test enable and bit copy done");
    end_sim;
  end
endmodule // testbench
